// >>> src/ds3_align_pkg.sv
// Constants, types and register map for the receive frame alignment engine
package ds3_align_pkg;

	// Timing
	localparam int CLK_PERIOD_NS      = 10;
	localparam int REFRAME_LIMIT_US   = 1500;
	localparam int REFRAME_LIMIT_CYC  = REFRAME_LIMIT_US * 1000 / CLK_PERIOD_NS;

	// Frame geometry
	localparam int BLOCK_BITS         = 85;
	localparam int SUBFRAMES          = 7;
	localparam int F_SPACING          = 2 * BLOCK_BITS;
	localparam logic [7:0] F_GAP      = 8'(F_SPACING - 1);
	localparam logic [6:0] LAST_BIB   = 7'(BLOCK_BITS - 1);
	localparam logic [2:0] LAST_BLK   = 3'h7;
	localparam logic [2:0] LAST_SF    = 3'(SUBFRAMES - 1);
	localparam logic [2:0] SF_P_FIRST = 3'h2;
	localparam logic [2:0] SF_P_LAST  = 3'h3;
	localparam logic [2:0] SF_M_FIRST = 3'h4;
	localparam logic [2:0] SF_M_ONE   = 3'h5;
	localparam logic [2:0] M_PATTERN  = 3'b010;

	// Acquisition and maintenance criteria
	localparam int F_CANDIDATES       = 5;
	localparam logic [3:0] F_LOCK_COUNT = 4'ha;
	localparam logic [1:0] M_LOCK_FRAMES = 2'h3;
	localparam int F_WIN              = 16;
	localparam logic [4:0] F_THR_LOOSE = 5'h06;
	localparam logic [4:0] F_THR_TIGHT = 5'h03;
	localparam int M_WIN              = 4;
	localparam logic [4:0] M_THR      = 5'h03;
	localparam int P_WIN              = 5;
	localparam logic [4:0] P_THR      = 5'h02;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_IO_CTRL  = 8'h01;
	localparam logic [7:0] IDX_RX_CFG   = 8'h10;
	localparam logic [7:0] IDX_FRM_STAT = 8'h11;
	localparam logic [7:0] ADDR_IO_CTRL  = 8'(IDX_IO_CTRL * 4);
	localparam logic [7:0] ADDR_RX_CFG   = 8'(IDX_RX_CFG * 4);
	localparam logic [7:0] ADDR_FRM_STAT = 8'(IDX_FRM_STAT * 4);

	localparam logic [7:0] IO_CTRL_RST   = 8'ha0;
	localparam logic [7:0] IO_CTRL_WMASK = 8'hbe;
	localparam logic [3:0] RX_CFG_RST    = 4'h0;
	localparam int IO_REFRAME_BIT = 0;
	localparam int IO_CLK_INV_BIT = 1;
	localparam int CFG_ALIGN_BIT  = 4;
	localparam int CFG_PARITY_BIT = 2;
	localparam int CFG_FSYNC_BIT  = 1;
	localparam int CFG_MSYNC_BIT  = 0;
	localparam int STAT_OVR_BIT   = 3;

	localparam int RX_FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		ST_F_SEARCH = 3'b000,
		ST_M_SEARCH = 3'b001,
		ST_P_CHECK  = 3'b010,
		ST_IN_FRAME = 3'b011
	} align_state_t;

	typedef struct packed {
		logic payload;
		logic overhead;
		logic aligned;
	} rx_word_t;

	localparam int RX_WORD_W = $bits(rx_word_t);

endpackage

// >>> src/ds3_rx_frame_alignment.sv
// Receive frame alignment engine with APB registers and output buffer
// Notes on behaviour
// - F search, M search and parity check acquire; in-frame state maintains.
// - F-bits follow 1001; five candidate alignments are searched concurrently.
// - Ten consecutive correct F-bits on one candidate end F search; go M search.
// - M-bits follow 010; three good M-frames in a row give in-frame.
// - Entering in-frame pulses change request, lowers pin, clears status bit 4.
// - Parity framing bit 2 set adds a valid parity check before in-frame.
// - With parity framing, parity errors in 2 of last 5 M-frames lose alignment.
// - Alignment lost on 6 of 16 bad F-bits, or 3 of 16 when selected.
// - M-sync bit 0 clear ignores M errors; set loses alignment on 3 of 4.
// - Loss of alignment returns the engine to F search.
// - Loss from in-frame drives pin high and sets status bit to 1.
// - Every change of the alignment status issues a change request.
// - Writing 1 to reframe bit forces F search, pin high, change request.
// - Average reframe time stays below 1.5 ms.
// - In frame, F and M bit positions are checked continuously.
`timescale 1ns/1ps

module rx_bit_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire              empty = wr_ptr == rd_ptr;
	wire              push  = in_valid_i & ~full;
	wire              pop   = out_valid_o & out_ready_i;

	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

module ds3_rx_frame_alignment
	import ds3_align_pkg::*;
#(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_B_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        RX_LINE_CLK_I,
	input  wire logic        RX_LINE_DATA_I,
	output logic             RX_FRAME_LOST_FLAG_O,
	output logic             RX_ALIGN_CHANGE_O,
	output logic             RX_WORD_VALID_O,
	input  wire logic        RX_WORD_READY_I,
	output rx_word_t         RX_WORD_O
);
	function automatic logic [4:0] ones16(input logic [15:0] v);
		logic [4:0] n;
		n = '0;
		for (int i = 0; i < 16; i++) begin
			n = n + 5'(v[i]);
		end
		return n;
	endfunction

	align_state_t        state;
	align_state_t        next_state;
	logic [7:0]          io_ctrl;
	logic [3:0]          rx_cfg;
	logic                out_of_alignment;
	logic                overrun;
	logic [7:0]          prdata;
	logic [2:0]          clk_sync;
	logic [1:0]          data_sync;
	logic [6:0]          bib;
	logic [2:0]          blk;
	logic [2:0]          sf;
	logic [6:0]          xpm_sr;
	logic [1:0]          m_cnt;
	logic                par_acc;
	logic                par_last;
	logic                par_valid;
	logic                p_err_first;
	logic [F_WIN-1:0]    f_win;
	logic [M_WIN-1:0]    m_win;
	logic [P_WIN-1:0]    p_win;
	logic                change;

	// Register bus decode
	wire sel_io     = PADDR_I == ADDR_IO_CTRL;
	wire sel_cfg    = PADDR_I == ADDR_RX_CFG;
	wire sel_stat   = PADDR_I == ADDR_FRM_STAT;
	wire addr_hit   = sel_io | sel_cfg | sel_stat;
	wire access     = PSEL_I & PENABLE_I;
	wire wr_en      = access & PWRITE_I;
	wire reframe    = wr_en & sel_io & PWDATA_I[IO_REFRAME_BIT];
	wire ovr_clr    = wr_en & sel_stat & PWDATA_I[STAT_OVR_BIT];
	wire [7:0] cfg_rd = {3'h0, out_of_alignment, rx_cfg};
	wire [7:0] stat_rd = {4'h0, overrun, state};
	wire [7:0] rd_mux = sel_io ? io_ctrl : sel_cfg ? cfg_rd : sel_stat ? stat_rd : 8'h00;

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = access & ~addr_hit;
	assign PRDATA_O  = {24'h000000, prdata};

	wire cfg_parity = rx_cfg[CFG_PARITY_BIT];
	wire cfg_fsync  = rx_cfg[CFG_FSYNC_BIT];
	wire cfg_msync  = rx_cfg[CFG_MSYNC_BIT];

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			io_ctrl <= IO_CTRL_RST;
			rx_cfg  <= RX_CFG_RST;
			prdata  <= 8'h00;
		end else begin
			if (wr_en && sel_io) begin
				io_ctrl <= PWDATA_I[7:0] & IO_CTRL_WMASK;
			end
			if (wr_en && sel_cfg) begin
				rx_cfg <= PWDATA_I[3:0];
			end
			if (PSEL_I && !PENABLE_I) begin
				prdata <= rd_mux;
			end
		end
	end

	// Line clock and data pass two flops before any use
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			clk_sync  <= 3'h0;
			data_sync <= 2'h0;
		end else begin
			clk_sync  <= {clk_sync[1:0], RX_LINE_CLK_I};
			data_sync <= {data_sync[0], RX_LINE_DATA_I};
		end
	end

	wire rise    = clk_sync[1] & ~clk_sync[2];
	wire fall    = ~clk_sync[1] & clk_sync[2];
	wire bit_stb = io_ctrl[IO_CLK_INV_BIT] ? fall : rise;
	wire bit_val = data_sync[1];

	// Bit position within the M-frame
	wire is_oh    = bib == 7'h00;
	wire f_pos    = bit_stb & is_oh & blk[0];
	wire f_exp    = (blk == 3'h1) | (blk == LAST_BLK);
	wire f_err    = f_pos & (bit_val != f_exp);
	wire xpm_pos  = bit_stb & is_oh & (blk == 3'h0);
	wire m_pos    = xpm_pos & (sf >= SF_M_FIRST);
	wire m_err    = m_pos & (bit_val != (sf == SF_M_ONE));
	wire p_pos    = xpm_pos & ((sf == SF_P_FIRST) | (sf == SF_P_LAST));
	wire p_bad    = bit_val != par_last;
	wire frm_end  = bit_stb & (bib == LAST_BIB) & (blk == LAST_BLK) & (sf == LAST_SF);
	wire p_done   = p_pos & (sf == SF_P_LAST) & par_valid;
	wire p_frm_err = p_bad | p_err_first;

	// Five concurrent F-bit candidate searches
	logic [F_CANDIDATES-1:0]      cand_act;
	logic [F_CANDIDATES-1:0]      cand_lock;
	logic [F_CANDIDATES-1:0][1:0] cand_hist;
	logic [F_CANDIDATES-1:0]      cand_free_lo;
	wire  [F_CANDIDATES-1:0]      alloc = ~cand_act & ~cand_free_lo;
	wire                          lock_hit = |cand_lock;
	wire                          in_fsearch = state == ST_F_SEARCH;
	localparam logic [7:0]        F_HOP = 8'(F_CANDIDATES - 1);

	always_comb begin
		cand_free_lo[0] = 1'b0;
		for (int k = 1; k < F_CANDIDATES; k++) begin
			cand_free_lo[k] = cand_free_lo[k-1] | ~cand_act[k-1];
		end
	end

	for (genvar k = 0; k < F_CANDIDATES; k++) begin : g_cand
		logic       act;
		logic [7:0] cd;
		logic [1:0] hist;
		logic [3:0] cnt;
		wire        test = act & (cd == 8'h00);
		wire        ok   = (cnt < 4'h2) | (bit_val == ~hist[1]);
		assign cand_act[k]  = act;
		assign cand_hist[k] = hist;
		assign cand_lock[k] = bit_stb & in_fsearch & test & ok & (cnt == F_LOCK_COUNT - 4'h1);
		always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				act  <= 1'b0;
				cd   <= 8'h00;
				hist <= 2'h0;
				cnt  <= 4'h0;
			end else if (bit_stb) begin
				if (!in_fsearch || lock_hit || reframe) begin
					act <= 1'b0;
				end else if (alloc[k]) begin
					act  <= 1'b1;
					cd   <= F_GAP;
					hist <= {1'b0, bit_val};
					cnt  <= 4'h1;
				end else if (test && ok) begin
					cd   <= F_GAP;
					hist <= {hist[0], bit_val};
					cnt  <= cnt + 4'h1;
				end else if (test) begin
					// Failed phase hops by the candidate count so five searches sweep in step
					cd  <= F_HOP;
					cnt <= 4'h0;
				end else if (act) begin
					cd <= cd - 8'h01;
				end
			end
		end
	end

	// Block holding the locking F-bit, from the last two F-bits seen
	logic [1:0] lock_pair;
	always_comb begin
		lock_pair = 2'h0;
		for (int k = F_CANDIDATES - 1; k >= 0; k--) begin
			if (cand_lock[k]) begin
				lock_pair = {cand_hist[k][0], bit_val};
			end
		end
	end
	wire [2:0] lock_blk = (lock_pair == 2'b11) ? 3'h1 : (lock_pair == 2'b10) ? 3'h3 :
		(lock_pair == 2'b00) ? 3'h5 : 3'h7;

	// M-bit search over the X/P/M overhead bit of each subframe
	wire [6:0] nsr     = {xpm_sr[5:0], bit_val};
	wire       m_match = (nsr[2:0] == M_PATTERN) & (nsr[6] == nsr[5]) & (nsr[4] == nsr[3]);
	wire [1:0] next_m_cnt = (sf == LAST_SF) ? m_cnt + 2'h1 : 2'h1;
	wire       m_search = state == ST_M_SEARCH;
	wire       m_realign = m_search & xpm_pos & m_match;
	wire       m_lost  = m_search & ((xpm_pos & ~m_match & (sf == LAST_SF) & (m_cnt != 2'h0)) | f_err);
	wire       m_lock  = m_realign & (next_m_cnt == M_LOCK_FRAMES);

	// Maintenance windows and loss-of-alignment decision
	wire in_frame = state == ST_IN_FRAME;
	wire [F_WIN-1:0] f_win_next = f_pos ? {f_win[F_WIN-2:0], f_err} : f_win;
	wire [M_WIN-1:0] m_win_next = m_pos ? {m_win[M_WIN-2:0], m_err} : m_win;
	wire [P_WIN-1:0] p_win_next = p_done ? {p_win[P_WIN-2:0], p_frm_err} : p_win;
	wire [4:0] f_thr   = cfg_fsync ? F_THR_TIGHT : F_THR_LOOSE;
	wire       f_fail  = ones16(16'(f_win_next)) >= f_thr;
	wire       m_fail  = cfg_msync & (ones16(16'(m_win_next)) >= M_THR);
	wire       p_fail  = cfg_parity & (ones16(16'(p_win_next)) >= P_THR);
	wire       declare = in_frame & (f_fail | m_fail | p_fail);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_F_SEARCH: begin
				if (lock_hit) begin
					next_state = ST_M_SEARCH;
				end
			end
			ST_M_SEARCH: begin
				if (m_lost) begin
					next_state = ST_F_SEARCH;
				end else if (m_lock) begin
					next_state = cfg_parity ? ST_P_CHECK : ST_IN_FRAME;
				end
			end
			ST_P_CHECK: begin
				if (f_err || (p_done && p_frm_err)) begin
					next_state = ST_F_SEARCH;
				end else if (p_done) begin
					next_state = ST_IN_FRAME;
				end
			end
			ST_IN_FRAME: begin
				if (declare) begin
					next_state = ST_F_SEARCH;
				end
			end
			default: next_state = ST_F_SEARCH;
		endcase
		if (reframe) begin
			next_state = ST_F_SEARCH;
		end
	end

	// Status flag follows the acquisition and maintenance modes
	wire next_out_of_alignment = (next_state != ST_IN_FRAME);
	assign change = (next_out_of_alignment != out_of_alignment) | reframe;

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state            <= ST_F_SEARCH;
			out_of_alignment <= 1'b1;
			RX_ALIGN_CHANGE_O <= 1'b0;
		end else begin
			state            <= next_state;
			out_of_alignment <= next_out_of_alignment;
			RX_ALIGN_CHANGE_O <= change;
		end
	end

	assign RX_FRAME_LOST_FLAG_O = out_of_alignment;

	// Position counters, parity accumulation and windows
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			bib <= 7'h00;
			blk <= 3'h0;
			sf  <= 3'h0;
		end else if (bit_stb) begin
			if (lock_hit) begin
				bib <= 7'h01;
				blk <= lock_blk;
				sf  <= 3'h0;
			end else begin
				bib <= (bib == LAST_BIB) ? 7'h00 : bib + 7'h01;
				if (bib == LAST_BIB) begin
					blk <= blk + 3'h1;
				end
				if (m_realign) begin
					sf <= LAST_SF;
				end else if (bib == LAST_BIB && blk == LAST_BLK) begin
					sf <= (sf == LAST_SF) ? 3'h0 : sf + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			xpm_sr <= 7'h00;
			m_cnt  <= 2'h0;
		end else if (in_fsearch) begin
			m_cnt <= 2'h0;
		end else if (m_realign) begin
			xpm_sr <= nsr;
			m_cnt  <= next_m_cnt;
		end else if (xpm_pos) begin
			xpm_sr <= nsr;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			par_acc     <= 1'b0;
			par_last    <= 1'b0;
			par_valid   <= 1'b0;
			p_err_first <= 1'b0;
		end else if (in_fsearch || m_realign) begin
			par_acc   <= 1'b0;
			par_valid <= 1'b0;
		end else if (frm_end) begin
			par_acc   <= 1'b0;
			par_last  <= par_acc ^ bit_val;
			par_valid <= 1'b1;
		end else if (bit_stb) begin
			if (!is_oh) begin
				par_acc <= par_acc ^ bit_val;
			end
			if (p_pos && sf == SF_P_FIRST) begin
				p_err_first <= p_bad;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			f_win <= '0;
			m_win <= '0;
			p_win <= '0;
		end else if (!in_frame) begin
			f_win <= '0;
			m_win <= '0;
			p_win <= '0;
		end else begin
			f_win <= f_win_next;
			m_win <= m_win_next;
			p_win <= p_win_next;
		end
	end

	// Recovered bits enter the output buffer; a full buffer drops bits
	rx_word_t push_word;
	logic     push_ready;
	assign push_word = '{payload: bit_val, overhead: is_oh & in_frame, aligned: in_frame};

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			overrun <= 1'b0;
		end else if (bit_stb && !push_ready) begin
			overrun <= 1'b1;
		end else if (ovr_clr) begin
			overrun <= 1'b0;
		end
	end

	rx_bit_fifo #(
		.WIDTH (RX_WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (SYS_CLK_I),
		.rst_b_i     (RST_B_I),
		.in_valid_i  (bit_stb),
		.in_data_i   (push_word),
		.in_ready_o  (push_ready),
		.out_valid_o (RX_WORD_VALID_O),
		.out_ready_i (RX_WORD_READY_I),
		.out_data_o  (RX_WORD_O)
	);

	// Checks; the search runs five candidates so the mean reframe stays short
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	a_acq_mode_flag: assert property (in_frame |-> !out_of_alignment)
		else $error("status flag high while in frame");
	a_fsearch_exit: assert property ($past(state) == ST_F_SEARCH && m_search |-> $past(lock_hit))
		else $error("left F search without a ten bit lock");
	a_mlock_count: assert property (m_lock |-> m_cnt == 2'h2 && sf == LAST_SF)
		else $error("M lock before three good M-frames");
	a_inframe_entry: assert property (!in_frame ##1 in_frame |-> !RX_FRAME_LOST_FLAG_O && $past(change))
		else $error("in-frame entry without pin low and change");
	a_parity_gate: assert property (m_search && m_lock && cfg_parity |=> state == ST_P_CHECK)
		else $error("parity check skipped while enabled");
	a_fwin_loss: assert property (in_frame && f_fail && !reframe |=> in_fsearch ##0 out_of_alignment)
		else $error("F error window did not drop alignment");
	a_mbit_loss: assert property (in_frame && m_pos && !f_fail && !p_fail && !reframe && !cfg_msync |=> in_frame)
		else $error("M errors dropped alignment while ignored");
	a_loss_pin: assert property (in_frame ##1 !in_frame |-> RX_FRAME_LOST_FLAG_O && in_fsearch)
		else $error("alignment loss without pin high in F search");
	a_change_each: assert property (RX_FRAME_LOST_FLAG_O != $past(RX_FRAME_LOST_FLAG_O) |-> RX_ALIGN_CHANGE_O)
		else $error("status change without change request");
	a_reframe_cmd: assert property (reframe |=> in_fsearch && RX_FRAME_LOST_FLAG_O && RX_ALIGN_CHANGE_O)
		else $error("reframe write not honoured");
	a_parity_loss: assert property (in_frame && p_fail && !reframe |=> in_fsearch)
		else $error("parity window did not drop alignment");

	c_reach_frame: cover property (m_search ##1 in_frame);
	c_parity_frame: cover property (state == ST_P_CHECK ##1 in_frame);
	c_lose_frame: cover property (in_frame && f_fail);
	c_reframe_in: cover property (in_frame && reframe);
	c_fifo_full: cover property (bit_stb && !push_ready);
endmodule

// >>> verif/ds3_line_source.sv
// Line side model that sends a framed bit stream with selectable overhead errors
`timescale 1ns/1ps
module ds3_line_source (
	input  wire logic       run_i,
	input  wire logic [2:0] inv_i,
	output logic            line_clk_o,
	output logic            line_data_o,
	output int              cnt_o [3]
);
	int   b, k, s;
	logic par, last_par, alt, d;

	initial begin
		line_clk_o = 1'b0;
		line_data_o = 1'b0;
		b = 0;
		k = 0;
		s = 0;
		par = 1'b0;
		last_par = 1'b0;
		alt = 1'b0;
		cnt_o = '{0, 0, 0};
		#3;
		forever begin
			line_clk_o = 1'b0;
			if (run_i !== 1'b1) begin
				// Clock stands still, data keeps moving so no stale bit shows
				line_data_o = ~line_data_o;
				#160;
			end else begin
				if (b != 0) begin
					alt = ~alt;
					d = alt;
					par = par ^ alt;
				end else if (k == 0 && s < 2) begin
					d = 1'b1;
				end else if (k == 0 && s < 4) begin
					d = last_par ^ inv_i[2];
					cnt_o[2]++;
				end else if (k == 0) begin
					d = (s == 5) ^ inv_i[1];
					cnt_o[1]++;
				end else if (k[0]) begin
					d = (k == 1 || k == 7) ^ inv_i[0];
					cnt_o[0]++;
				end else begin
					d = 1'b0;
				end
				line_data_o = d;
				#80;
				line_clk_o = 1'b1;
				#80;
				b = b + 1;
				if (b == 85) begin
					b = 0;
					k = k + 1;
				end
				if (k == 8) begin
					k = 0;
					s = s + 1;
				end
				if (s == 7) begin
					s = 0;
					last_par = par;
					par = 1'b0;
				end
			end
		end
	end
endmodule

// >>> verif/ds3_rx_frame_alignment_bench.sv
// Self-checking bench for the receive frame alignment engine
`timescale 1ns/1ps
module ds3_rx_frame_alignment_bench;
	import ds3_align_pkg::*;

	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        lclk, ldata, flag, chg, wvalid, ready, run;
	logic [2:0]  inv;
	rx_word_t    word;
	int          cnt [3];
	int          pulses, bad_count, check_count;

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (chg === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	ds3_rx_frame_alignment ds3_rx_frame_alignment_inst (
		.SYS_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .RX_LINE_CLK_I(lclk),
		.RX_LINE_DATA_I(ldata), .RX_FRAME_LOST_FLAG_O(flag), .RX_ALIGN_CHANGE_O(chg),
		.RX_WORD_VALID_O(wvalid), .RX_WORD_READY_I(ready), .RX_WORD_O(word)
	);

	ds3_line_source ds3_line_source_inst (
		.run_i(run), .inv_i(inv), .line_clk_o(lclk), .line_data_o(ldata), .cnt_o(cnt)
	);

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic hang(input string what);
		bad_count++;
		$display("MISMATCH t=%0t timeout %s", $time, what);
		final_report();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) hang("apb");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp, what);
	endtask

	task automatic wait_flag(input logic v, input int lim);
		int n;
		n = 0;
		while (flag !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) hang("flag");
	endtask

	// Lets n overhead bits of one kind pass, inverted when bad is set
	task automatic inject(input int kind, input int n, input logic bad);
		int start, t;
		@(posedge clk);
		t = 0;
		while (kind == 2 && cnt[2][0] == 1'b1 && t < 100000) begin
			@(posedge clk);
			t++;
		end
		start = cnt[kind];
		inv[kind] <= bad;
		while (cnt[kind] < start + n && t < 400000) begin
			@(posedge clk);
			t++;
		end
		inv[kind] <= 1'b0;
		if (t >= 400000) hang("inject");
	endtask

	task automatic acquire(input logic [7:0] cfg);
		int p0;
		apb(1'b1, ADDR_RX_CFG, {24'h0, cfg});
		p0 = pulses;
		wait_flag(1'b0, 600000);
		rchk(ADDR_RX_CFG, {28'h0, cfg[3:0]}, "status clear");
		rchk(ADDR_FRM_STAT, 32'h0000_0003, "in frame");
		chk(pulses - p0, 1, "lock pulse");
	endtask

	task automatic t_regs;
		int p0;
		chk(flag, 1'b1, "flag reset");
		rchk(ADDR_IO_CTRL, 32'h0000_00a0, "io reset");
		rchk(ADDR_RX_CFG, 32'h0000_0010, "cfg reset");
		p0 = pulses;
		apb(1'b1, ADDR_IO_CTRL, 32'h0000_00ff);
		rchk(ADDR_IO_CTRL, 32'h0000_00be, "io mask");
		apb(1'b1, ADDR_IO_CTRL, 32'h0000_00a1);
		rchk(ADDR_FRM_STAT, 32'h0000_0000, "forced search");
		chk(pulses - p0, 2, "reframe pulses");
		apb(1'b1, ADDR_RX_CFG, 32'h0000_00ff);
		rchk(ADDR_RX_CFG, 32'h0000_001f, "cfg mask");
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(err, 1'b1, "unmapped read err");
		chk(rd, 32'h0000_0000, "unmapped read");
		apb(1'b1, 8'h08, 32'h0000_00ff);
		chk(err, 1'b1, "unmapped write err");
		rchk(ADDR_IO_CTRL, 32'h0000_00a0, "io kept");
		$display("done registers");
	endtask

	task automatic t_mbit;
		int p0, n;
		acquire(8'h00);
		ready <= 1'b0;
		repeat (400) @(posedge clk);
		chk(wvalid, 1'b1, "buffer full");
		chk(word.aligned, 1'b1, "aligned word");
		rchk(ADDR_FRM_STAT, 32'h0000_000b, "overrun");
		ready <= 1'b1;
		n = 0;
		while (wvalid !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) hang("drain");
		apb(1'b1, ADDR_FRM_STAT, 32'h0000_0008);
		rchk(ADDR_FRM_STAT, 32'h0000_0003, "overrun clear");
		inject(1, 4, 1'b1);
		inject(1, 4, 1'b0);
		chk(flag, 1'b0, "m errors ignored");
		apb(1'b1, ADDR_RX_CFG, 32'h0000_0001);
		inject(1, 2, 1'b1);
		inject(1, 2, 1'b0);
		chk(flag, 1'b0, "m two of four");
		p0 = pulses;
		inject(1, 3, 1'b1);
		wait_flag(1'b1, 100);
		rchk(ADDR_FRM_STAT, 32'h0000_0000, "back to search");
		rchk(ADDR_RX_CFG, 32'h0000_0011, "status set");
		chk(pulses - p0, 1, "loss pulse");
		$display("done m-bit");
	endtask

	task automatic t_fbit;
		int p0;
		acquire(8'h06);
		inject(0, 2, 1'b1);
		inject(0, 1, 1'b0);
		chk(flag, 1'b0, "f two bad");
		p0 = pulses;
		inject(0, 1, 1'b1);
		wait_flag(1'b1, 100);
		rchk(ADDR_RX_CFG, 32'h0000_0016, "status set");
		chk(pulses - p0, 1, "loss pulse");
		$display("done f-bit");
	endtask

	task automatic t_parity;
		acquire(8'h04);
		inject(2, 2, 1'b1);
		inject(2, 2, 1'b0);
		chk(flag, 1'b0, "one parity frame");
		inject(0, 5, 1'b1);
		inject(0, 1, 1'b0);
		chk(flag, 1'b0, "f five bad");
		inject(2, 2, 1'b1);
		wait_flag(1'b1, 80000);
		$display("done parity");
	endtask

	task automatic t_reframe;
		int p0;
		apb(1'b1, ADDR_IO_CTRL, 32'h0000_00a3);
		rchk(ADDR_IO_CTRL, 32'h0000_00a2, "invert set");
		acquire(8'h00);
		p0 = pulses;
		apb(1'b1, ADDR_IO_CTRL, 32'h0000_00a1);
		rchk(ADDR_FRM_STAT, 32'h0000_0000, "forced search");
		chk(flag, 1'b1, "flag high");
		chk(pulses - p0, 1, "reframe pulse");
		$display("done reframe");
	endtask

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		ready = 1'b1;
		run = 1'b0;
		inv = 3'h0;
		pulses = 0;
		bad_count = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		run <= 1'b1;
		t_mbit();
		t_fbit();
		t_parity();
		t_reframe();
		final_report();
	end
endmodule
